// ==== rtl/spfs_pkg.sv ====
// constants, carrier types and helpers of the shared pin function select block
// Summary of operation
// - general-purpose locations 0 to 12 and 30 are reserved, holding nothing.
// - first register fields 15:14 to 9:8 pick each two-wire clock pin; 00 clock.
// - first register fields 7:6 to 1:0 pick fiber signal detect pins; 00 detect.
// - any pin field holding 11 hands the pin to plain GPIO control.
// - second register 15:14 sets both timestamp serial pins; 11 makes GPIO 12/13.
// - bit 13 low drives the low-power-hold pin; high, the reset value, keeps input.
// - a driven low-power-hold pin shows bit 12, which resets to zero.
// - read-only bit 11 returns the sampled low-power-hold pin level.
// - bit 10 set floats two-wire outputs instead of driving them high.
// - bit 9 set floats LED outputs instead of driving them high.
// - bit 8 enables the three extra pulse-per-second outputs; resets to zero.
// - bits 7:6 pick the primary pulse-per-second pin; 11 makes GPIO eleven.
// - bits 5:4 pick the time load/save strobe pin; 11 makes GPIO ten.
// - bits 3:2 pick the fast-link-failure pin; 11 makes GPIO nine.
// - bits 1:0 pick the shared two-wire data pin; 11 makes GPIO eight.
// - page register 31 at 0x0010 reaches this global page; 0x0000 returns.
// - a GPIO pin is driven from the output word when its enable bit is set.
package spfs_pkg;

  localparam int unsigned SPFS_DATA_W = 16;
  localparam int unsigned SPFS_ADDR_W = 5;
  localparam int unsigned SPFS_PIN_COUNT = 14;
  localparam int unsigned SPFS_PPS_EXTRA_COUNT = 3;

  localparam logic [4:0] SPFS_ADDR_SEL_A = 5'h0d;
  localparam logic [4:0] SPFS_ADDR_SEL_B = 5'h0e;
  localparam logic [4:0] SPFS_ADDR_PAGE = 5'h1f;
  localparam logic [15:0] SPFS_PAGE_GP = 16'h0010;
  localparam logic [15:0] SPFS_PAGE_MAIN = 16'h0000;

  localparam logic [15:0] SPFS_SEL_A_RESET = 16'h0000;
  localparam logic [15:0] SPFS_SEL_B_RESET = 16'h2600;

  // two-bit select fields, one flag bit per field low bit
  localparam logic [15:0] SPFS_SEL_A_FIELDS = 16'h5555;
  localparam logic [15:0] SPFS_SEL_B_FIELDS = 16'h4055;
  localparam logic [1:0] SPFS_CODE_FUNC = 2'h0;
  localparam logic [1:0] SPFS_CODE_GPIO = 2'h3;

  localparam int unsigned SPFS_B_HOLD_OE_N = 13;
  localparam int unsigned SPFS_B_HOLD_DATA = 12;
  localparam int unsigned SPFS_B_HOLD_IN = 11;
  localparam int unsigned SPFS_B_TWI_FLOAT = 10;
  localparam int unsigned SPFS_B_LED_FLOAT = 9;
  localparam int unsigned SPFS_B_PPS_EXTRA = 8;
  // writable bits of the second register; bit 11 is the live pin level
  localparam logic [15:0] SPFS_SEL_B_WMASK = 16'hf7ff;

  localparam int unsigned SPFS_PIN_SCL0 = 4;
  localparam int unsigned SPFS_PIN_SDA = 8;
  localparam int unsigned SPFS_PIN_FLF = 9;
  localparam int unsigned SPFS_PIN_LOAD = 10;
  localparam int unsigned SPFS_PIN_PPS = 11;
  localparam int unsigned SPFS_PIN_CS = 12;
  localparam int unsigned SPFS_PIN_DO = 13;

  typedef struct packed {
    logic mode_gpio;
    logic float_high;
    logic func_out;
    logic func_oe;
    logic gpio_out;
    logic gpio_oe;
  } spfs_pin_ctl_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } spfs_mgmt_req_t;

  // a reserved code written into a field keeps the field's old value
  function automatic logic [15:0] spfs_filter_codes(input logic [15:0] old_val,
                                                    input logic [15:0] new_val,
                                                    input logic [15:0] fields);
    logic [15:0] res;
    res = new_val;
    for (int i = 0; i < 16; i += 2) begin
      if (fields[i] && (new_val[i+1] != new_val[i])) begin
        res[i+1 -: 2] = old_val[i+1 -: 2];
      end
    end
    return res;
  endfunction : spfs_filter_codes

endpackage : spfs_pkg

// ==== rtl/spfs_pin_cell.sv ====
// one shared pad: function or GPIO source, float-high option, registered pad drive
`timescale 1ns/10ps
module spfs_pin_cell
  import spfs_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire spfs_pin_ctl_t ctl_i,
  input wire logic pad_i,
  output logic pad_o,
  output logic pad_oe_o,
  output logic func_in_o,
  output logic gpio_in_o
);

  logic pad_reg, pad_next;
  logic oe_reg, oe_next;
  logic func_in_reg, func_in_next;
  logic gpio_in_reg, gpio_in_next;
  logic drv_val;
  logic drv_en;

  always_comb begin
    drv_val = ctl_i.mode_gpio ? ctl_i.gpio_out : ctl_i.func_out;
    drv_en = ctl_i.mode_gpio ? ctl_i.gpio_oe : ctl_i.func_oe;
    pad_next = drv_val;
    // a float-high pad lets the external pull-up make the one
    oe_next = drv_en && !(ctl_i.float_high && drv_val);
    // the core sees a quiet zero once the pad belongs to GPIO
    func_in_next = ctl_i.mode_gpio ? 1'b0 : pad_i;
    gpio_in_next = pad_i;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pad_reg <= 1'b0;
      oe_reg <= 1'b0;
      func_in_reg <= 1'b0;
      gpio_in_reg <= 1'b0;
    end else if (ce_i) begin
      pad_reg <= pad_next;
      oe_reg <= oe_next;
      func_in_reg <= func_in_next;
      gpio_in_reg <= gpio_in_next;
    end
  end

  assign pad_o = pad_reg;
  assign pad_oe_o = oe_reg;
  assign func_in_o = func_in_reg;
  assign gpio_in_o = gpio_in_reg;

endmodule : spfs_pin_cell

// ==== rtl/spfs_mgmt_port.sv ====
// management access: page register, decode of the two select registers, read data
`timescale 1ns/10ps
module spfs_mgmt_port
  import spfs_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire spfs_mgmt_req_t req_i,
  input wire logic [15:0] sel_a_i,
  input wire logic [15:0] sel_b_i,
  output logic wr_a_o,
  output logic wr_b_o,
  output logic gp_page_o,
  output logic [15:0] rdata_o,
  output logic rvalid_o
);

  logic [15:0] page_reg, page_next;
  logic [15:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic gp_page;

  assign gp_page = (page_reg == SPFS_PAGE_GP);

  always_comb begin
    page_next = page_reg;
    if (req_i.wr && (req_i.addr == SPFS_ADDR_PAGE)) begin
      page_next = req_i.wdata;
    end
    wr_a_o = req_i.wr && gp_page && (req_i.addr == SPFS_ADDR_SEL_A);
    wr_b_o = req_i.wr && gp_page && (req_i.addr == SPFS_ADDR_SEL_B);
    rvalid_next = req_i.rd;
    rdata_next = rdata_reg;
    if (req_i.rd) begin
      // reserved and foreign locations answer zero
      if (req_i.addr == SPFS_ADDR_PAGE) begin
        rdata_next = page_reg;
      end else if (gp_page && (req_i.addr == SPFS_ADDR_SEL_A)) begin
        rdata_next = sel_a_i;
      end else if (gp_page && (req_i.addr == SPFS_ADDR_SEL_B)) begin
        rdata_next = sel_b_i;
      end else begin
        rdata_next = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      page_reg <= SPFS_PAGE_MAIN;
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else if (ce_i) begin
      page_reg <= page_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign gp_page_o = gp_page;
  assign rdata_o = rdata_reg;
  assign rvalid_o = rvalid_reg;

endmodule : spfs_mgmt_port

// ==== rtl/spfs_top.sv ====
// shared pin function select: select registers, pad routing, hold pin, LED and pps pads
`timescale 1ns/10ps
module spfs_top
  import spfs_pkg::*;
#(
  parameter int unsigned LED_COUNT = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [4:0] mgmt_addr_i,
  input wire logic [15:0] mgmt_wdata_i,
  input wire logic mgmt_wr_i,
  input wire logic mgmt_rd_i,
  output logic [15:0] mgmt_rdata_o,
  output logic mgmt_rvalid_o,
  output logic gp_page_active_o,
  input wire logic [13:0] core_out_i,
  input wire logic [13:0] core_oe_i,
  output logic [13:0] core_in_o,
  input wire logic [13:0] gpio_out_i,
  input wire logic [13:0] gpio_oe_i,
  output logic [13:0] gpio_in_o,
  input wire logic [13:0] shared_pad_i,
  output logic [13:0] shared_pad_o,
  output logic [13:0] shared_pad_oe_o,
  input wire logic [LED_COUNT-1:0] led_i,
  input wire logic [LED_COUNT-1:0] led_pad_i,
  output logic [LED_COUNT-1:0] led_pad_o,
  output logic [LED_COUNT-1:0] led_pad_oe_o,
  input wire logic [2:0] pps_extra_i,
  output logic [2:0] pps_extra_o,
  output logic [2:0] pps_extra_oe_o,
  input wire logic low_power_hold_pin_i,
  output logic low_power_hold_pin_o,
  output logic low_power_hold_pin_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // management access

  spfs_mgmt_req_t mgmt_req;
  logic wr_a;
  logic wr_b;
  logic gp_page;
  logic [15:0] sel_a_reg, sel_a_next;
  logic [15:0] sel_b_reg, sel_b_next;
  logic hold_in_reg, hold_in_next;
  logic [15:0] sel_b_view;
  logic gp_page_reg;

  assign mgmt_req.addr = mgmt_addr_i;
  assign mgmt_req.wdata = mgmt_wdata_i;
  assign mgmt_req.wr = mgmt_wr_i;
  assign mgmt_req.rd = mgmt_rd_i;

  // bit 11 always shows the sampled pin, never the stored value
  always_comb begin
    sel_b_view = sel_b_reg;
    sel_b_view[SPFS_B_HOLD_IN] = hold_in_reg;
  end

  spfs_mgmt_port u_mgmt (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .req_i(mgmt_req),
    .sel_a_i(sel_a_reg),
    .sel_b_i(sel_b_view),
    .wr_a_o(wr_a),
    .wr_b_o(wr_b),
    .gp_page_o(gp_page),
    .rdata_o(mgmt_rdata_o),
    .rvalid_o(mgmt_rvalid_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // select registers

  always_comb begin
    sel_a_next = sel_a_reg;
    sel_b_next = sel_b_reg;
    if (wr_a) begin
      // dropping reserved codes keeps every pin in a defined mode
      sel_a_next = spfs_filter_codes(sel_a_reg, mgmt_wdata_i, SPFS_SEL_A_FIELDS);
    end
    if (wr_b) begin
      sel_b_next = (spfs_filter_codes(sel_b_reg, mgmt_wdata_i, SPFS_SEL_B_FIELDS)
                    & SPFS_SEL_B_WMASK) | (sel_b_reg & ~SPFS_SEL_B_WMASK);
    end
    hold_in_next = low_power_hold_pin_i;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sel_a_reg <= SPFS_SEL_A_RESET;
      sel_b_reg <= SPFS_SEL_B_RESET;
      hold_in_reg <= 1'b0;
      gp_page_reg <= 1'b0;
    end else if (ce_i) begin
      sel_a_reg <= sel_a_next;
      sel_b_reg <= sel_b_next;
      hold_in_reg <= hold_in_next;
      gp_page_reg <= gp_page;
    end
  end

  assign gp_page_active_o = gp_page_reg;

  ////////////////////////////////////////////////////////////////////////////
  // per-pin mode decode

  logic [13:0] pin_gpio;
  logic [13:0] pin_float;
  logic twi_float;
  logic led_float;

  assign twi_float = sel_b_reg[SPFS_B_TWI_FLOAT];
  assign led_float = sel_b_reg[SPFS_B_LED_FLOAT];

  always_comb begin
    pin_gpio = '0;
    for (int i = 0; i < 4; i++) begin
      pin_gpio[i] = (sel_a_reg[2*i+1 -: 2] == SPFS_CODE_GPIO);
      pin_gpio[SPFS_PIN_SCL0+i] = (sel_a_reg[2*i+9 -: 2] == SPFS_CODE_GPIO);
    end
    pin_gpio[SPFS_PIN_SDA] = (sel_b_reg[1:0] == SPFS_CODE_GPIO);
    pin_gpio[SPFS_PIN_FLF] = (sel_b_reg[3:2] == SPFS_CODE_GPIO);
    pin_gpio[SPFS_PIN_LOAD] = (sel_b_reg[5:4] == SPFS_CODE_GPIO);
    pin_gpio[SPFS_PIN_PPS] = (sel_b_reg[7:6] == SPFS_CODE_GPIO);
    pin_gpio[SPFS_PIN_CS] = (sel_b_reg[15:14] == SPFS_CODE_GPIO);
    pin_gpio[SPFS_PIN_DO] = (sel_b_reg[15:14] == SPFS_CODE_GPIO);
    // only the two-wire clock and data pads obey the two-wire float bit
    pin_float = '0;
    for (int i = SPFS_PIN_SCL0; i <= SPFS_PIN_SDA; i++) begin
      pin_float[i] = twi_float;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared pads

  for (genvar p = 0; p < SPFS_PIN_COUNT; p++) begin : g_pin
    spfs_pin_ctl_t ctl;
    assign ctl.mode_gpio = pin_gpio[p];
    assign ctl.float_high = pin_float[p];
    assign ctl.func_out = core_out_i[p];
    assign ctl.func_oe = core_oe_i[p];
    assign ctl.gpio_out = gpio_out_i[p];
    assign ctl.gpio_oe = gpio_oe_i[p];
    spfs_pin_cell u_cell (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .ctl_i(ctl),
      .pad_i(shared_pad_i[p]),
      .pad_o(shared_pad_o[p]),
      .pad_oe_o(shared_pad_oe_o[p]),
      .func_in_o(core_in_o[p]),
      .gpio_in_o(gpio_in_o[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // LED pads: always driven by the LED logic, only the high level may float

  for (genvar l = 0; l < LED_COUNT; l++) begin : g_led
    spfs_pin_ctl_t ctl;
    assign ctl.mode_gpio = 1'b0;
    assign ctl.float_high = led_float;
    assign ctl.func_out = led_i[l];
    assign ctl.func_oe = 1'b1;
    assign ctl.gpio_out = 1'b0;
    assign ctl.gpio_oe = 1'b0;
    spfs_pin_cell u_cell (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .ctl_i(ctl),
      .pad_i(led_pad_i[l]),
      .pad_o(led_pad_o[l]),
      .pad_oe_o(led_pad_oe_o[l]),
      .func_in_o(),
      .gpio_in_o()
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // low-power-hold pin and extra pulse-per-second pads

  logic hold_out_reg, hold_out_next;
  logic hold_oe_reg, hold_oe_next;
  logic [2:0] pps_reg, pps_next;
  logic [2:0] pps_oe_reg, pps_oe_next;

  always_comb begin
    hold_oe_next = !sel_b_reg[SPFS_B_HOLD_OE_N];
    hold_out_next = sel_b_reg[SPFS_B_HOLD_DATA];
    pps_next = pps_extra_i;
    // left off, these pads stay free for the daisy-chain input
    pps_oe_next = {3{sel_b_reg[SPFS_B_PPS_EXTRA]}};
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      hold_out_reg <= 1'b0;
      hold_oe_reg <= 1'b0;
      pps_reg <= 3'h0;
      pps_oe_reg <= 3'h0;
    end else if (ce_i) begin
      hold_out_reg <= hold_out_next;
      hold_oe_reg <= hold_oe_next;
      pps_reg <= pps_next;
      pps_oe_reg <= pps_oe_next;
    end
  end

  assign low_power_hold_pin_o = hold_out_reg;
  assign low_power_hold_pin_oe_o = hold_oe_reg;
  assign pps_extra_o = pps_reg;
  assign pps_extra_oe_o = pps_oe_reg;

endmodule : spfs_top

// ==== test/spfs_asserts.sv ====
// port-level assertions of the shared pin function select block
`timescale 1ns/10ps
module spfs_asserts
  import spfs_pkg::*;
#(
  parameter int unsigned LED_COUNT = 16
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [4:0] mgmt_addr_i,
  input wire logic [15:0] mgmt_wdata_i,
  input wire logic mgmt_wr_i,
  input wire logic mgmt_rd_i,
  input wire logic [15:0] mgmt_rdata_o,
  input wire logic mgmt_rvalid_o,
  input wire logic gp_page_active_o,
  input wire logic [13:0] shared_pad_i,
  input wire logic [13:0] gpio_in_o,
  input wire logic [LED_COUNT-1:0] led_pad_o,
  input wire logic [LED_COUNT-1:0] led_pad_oe_o,
  input wire logic [2:0] pps_extra_oe_o,
  input wire logic low_power_hold_pin_o,
  input wire logic low_power_hold_pin_oe_o
);
  // page flag lags the page register, so trust it only two edges after a page write
  logic [1:0] quiet_reg;
  logic [1:0] quiet_next;
  always_comb begin
    quiet_next = quiet_reg;
    if (mgmt_wr_i && (mgmt_addr_i == SPFS_ADDR_PAGE)) begin
      quiet_next = 2'h0;
    end else if (ce_i && (quiet_reg != 2'h3)) begin
      quiet_next = quiet_reg + 2'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      quiet_reg <= 2'h0;
    end else begin
      quiet_reg <= quiet_next;
    end
  end
  //////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  sequence s_rd;
    mgmt_rd_i && ce_i;
  endsequence
  sequence s_wr_b;
    mgmt_wr_i && ce_i && (mgmt_addr_i == SPFS_ADDR_SEL_B) && gp_page_active_o && quiet_reg[1];
  endsequence
  property p_rd_answer;
    s_rd |=> mgmt_rvalid_o;
  endproperty
  property p_rsvd_zero;
    s_rd ##0 ((mgmt_addr_i <= 5'h0c) || (mgmt_addr_i == 5'h1e)) |=> mgmt_rdata_o == 16'h0000;
  endproperty
  property p_offpage_zero;
    s_rd ##0 ((mgmt_addr_i inside {5'h0d, 5'h0e}) && !gp_page_active_o && quiet_reg[1])
      |=> mgmt_rdata_o == 16'h0000;
  endproperty
  property p_hold_drive;
    s_wr_b ##0 !mgmt_wdata_i[13] ##1 ce_i
      |=> low_power_hold_pin_oe_o && (low_power_hold_pin_o == $past(mgmt_wdata_i[12], 2));
  endproperty
  property p_hold_input;
    s_wr_b ##0 mgmt_wdata_i[13] ##1 ce_i |=> !low_power_hold_pin_oe_o;
  endproperty
  property p_pps_oe;
    s_wr_b ##1 ce_i |=> pps_extra_oe_o == {3{$past(mgmt_wdata_i[8], 2)}};
  endproperty
  property p_led_drive;
    s_wr_b ##0 !mgmt_wdata_i[9] ##1 ce_i |=> &led_pad_oe_o;
  endproperty
  property p_led_float;
    !$past(srst_i) && $past(ce_i) |-> (~led_pad_oe_o & ~led_pad_o) == {LED_COUNT{1'b0}};
  endproperty
  property p_gpio_in;
    !$past(srst_i) && $past(ce_i) |-> gpio_in_o == $past(shared_pad_i);
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered");
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved location read nonzero");
  a_offpage_zero: assert property (p_offpage_zero)
    else $error("select register visible off page");
  a_hold_drive: assert property (p_hold_drive)
    else $error("hold pin not driven with stored bit");
  a_hold_input: assert property (p_hold_input)
    else $error("hold pin driven while input");
  a_pps_oe: assert property (p_pps_oe)
    else $error("extra pps enable mismatch");
  a_led_drive: assert property (p_led_drive)
    else $error("led not driven with float clear");
  a_led_float: assert property (p_led_float)
    else $error("led released while low");
  a_gpio_in: assert property (p_gpio_in)
    else $error("pad level not sampled");
endmodule : spfs_asserts

bind spfs_top spfs_asserts #(.LED_COUNT(LED_COUNT)) u_spfs_asserts (
  .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .mgmt_addr_i(mgmt_addr_i),
  .mgmt_wdata_i(mgmt_wdata_i), .mgmt_wr_i(mgmt_wr_i), .mgmt_rd_i(mgmt_rd_i),
  .mgmt_rdata_o(mgmt_rdata_o), .mgmt_rvalid_o(mgmt_rvalid_o),
  .gp_page_active_o(gp_page_active_o), .shared_pad_i(shared_pad_i), .gpio_in_o(gpio_in_o),
  .led_pad_o(led_pad_o), .led_pad_oe_o(led_pad_oe_o), .pps_extra_oe_o(pps_extra_oe_o),
  .low_power_hold_pin_o(low_power_hold_pin_o), .low_power_hold_pin_oe_o(low_power_hold_pin_oe_o)
);

// ==== test/spfs_board_model.sv ====
// board around the shared pads: pull-ups, external drivers, pad level resolution
`timescale 1ns/10ps
module spfs_board_model (
  input wire logic [13:0] pad_i,
  input wire logic [13:0] pad_oe_i,
  input wire logic [13:0] ext_i,
  input wire logic [15:0] led_i,
  input wire logic [15:0] led_oe_i,
  input wire logic hold_i,
  input wire logic hold_oe_i,
  input wire logic hold_ext_i,
  output logic [13:0] pad_lvl_o,
  output logic [15:0] led_lvl_o,
  output logic hold_lvl_o
);
  // two-wire pins carry pull-ups; the rest see a board driver when released
  localparam logic [13:0] PULLED = 14'h01f0;
  always_comb begin
    for (int k = 0; k < 14; k++) begin
      if (pad_oe_i[k]) begin
        pad_lvl_o[k] = pad_i[k];
      end else if (PULLED[k]) begin
        pad_lvl_o[k] = 1'b1;
      end else begin
        pad_lvl_o[k] = ext_i[k];
      end
    end
    led_lvl_o = (led_i & led_oe_i) | ~led_oe_i;
    hold_lvl_o = hold_oe_i ? hold_i : hold_ext_i;
  end
endmodule : spfs_board_model

// ==== test/spfs_top_tb_top.sv ====
// self-checking bench of the shared pin function select block
`timescale 1ns/10ps
module spfs_top_tb_top;
  import spfs_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic mgmt_wr = 1'b0;
  logic mgmt_rd = 1'b0;
  logic [15:0] rdata;
  logic rvalid;
  logic gp_act;
  logic [13:0] core_out = 14'h0000, core_oe = 14'h0000, gpio_out = 14'h0000;
  logic [13:0] gpio_oe = 14'h0000, ext = 14'h0000;
  logic [13:0] core_in, gpio_in, pad_lvl, pad_o, pad_oe;
  logic [15:0] led = 16'h0000;
  logic [15:0] led_lvl, led_o, led_oe;
  logic [2:0] pps = 3'h5;
  logic [2:0] pps_o, pps_oe;
  logic hold_ext = 1'b1;
  logic hold_lvl, hold_o, hold_oe;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;

  always #12.5 clk_i = ~clk_i;

  spfs_top #(.LED_COUNT(16)) DUT (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .mgmt_addr_i(addr), .mgmt_wdata_i(wdata),
    .mgmt_wr_i(mgmt_wr), .mgmt_rd_i(mgmt_rd), .mgmt_rdata_o(rdata), .mgmt_rvalid_o(rvalid),
    .gp_page_active_o(gp_act), .core_out_i(core_out), .core_oe_i(core_oe),
    .core_in_o(core_in), .gpio_out_i(gpio_out), .gpio_oe_i(gpio_oe), .gpio_in_o(gpio_in),
    .shared_pad_i(pad_lvl), .shared_pad_o(pad_o), .shared_pad_oe_o(pad_oe), .led_i(led),
    .led_pad_i(led_lvl), .led_pad_o(led_o), .led_pad_oe_o(led_oe), .pps_extra_i(pps),
    .pps_extra_o(pps_o), .pps_extra_oe_o(pps_oe), .low_power_hold_pin_i(hold_lvl),
    .low_power_hold_pin_o(hold_o), .low_power_hold_pin_oe_o(hold_oe)
  );

  spfs_board_model u_board (
    .pad_i(pad_o), .pad_oe_i(pad_oe), .ext_i(ext), .led_i(led_o), .led_oe_i(led_oe),
    .hold_i(hold_o), .hold_oe_i(hold_oe), .hold_ext_i(hold_ext), .pad_lvl_o(pad_lvl),
    .led_lvl_o(led_lvl), .hold_lvl_o(hold_lvl)
  );
  //////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    #2;
    addr = a;
    wdata = d;
    mgmt_wr = 1'b1;
    @(posedge clk_i);
    #2;
    mgmt_wr = 1'b0;
  endtask : wr

  // read answer is registered on the taking edge itself
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    #2;
    addr = a;
    mgmt_rd = 1'b1;
    @(posedge clk_i);
    #2;
    mgmt_rd = 1'b0;
    chk({15'h0000, rvalid}, 16'h0001);
    chk(rdata, exp);
  endtask : rd

  // pads sit one flop behind the select registers
  task automatic settle;
    repeat (2) @(posedge clk_i);
    #2;
  endtask : settle

  task automatic tally_and_finish;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_i);
    #2;
    srst_i = 1'b0;
    settle();
    chk({14'h0000, hold_oe, pps_oe[0]}, 16'h0000);
    rd(SPFS_ADDR_PAGE, SPFS_PAGE_MAIN);
    wr(SPFS_ADDR_PAGE, SPFS_PAGE_GP);
    rd(SPFS_ADDR_SEL_A, 16'h0000);
    rd(SPFS_ADDR_SEL_B, 16'h2e00);
    for (int a = 0; a < 31; a++) begin
      if (a < 13 || a == 30) begin
        wr(5'(a), 16'hffff);
        rd(5'(a), 16'h0000);
      end
    end
    wr(SPFS_ADDR_SEL_A, 16'h5555);
    rd(SPFS_ADDR_SEL_A, 16'h0000);
    wr(SPFS_ADDR_SEL_A, 16'haaaa);
    rd(SPFS_ADDR_SEL_A, 16'h0000);
    // every pin handed to the gpio words, two-wire pins driven both ways
    hold_ext = 1'b0;
    gpio_out = 14'h2a5a;
    gpio_oe = 14'h3fff;
    core_out = 14'h15a5;
    core_oe = 14'h3fff;
    wr(SPFS_ADDR_SEL_A, 16'hffff);
    wr(SPFS_ADDR_SEL_B, 16'he0ff);
    settle();
    chk({2'h0, pad_o}, 16'h2a5a);
    chk({2'h0, pad_oe}, 16'h3fff);
    gpio_oe = 14'h0000;
    ext = 14'h1234;
    settle();
    chk({2'h0, gpio_in}, 16'h13f4);
    chk({2'h0, core_in}, 16'h0000);
    chk({2'h0, pad_oe}, 16'h0000);
    rd(SPFS_ADDR_SEL_A, 16'hffff);
    rd(SPFS_ADDR_SEL_B, 16'he0ff);
    // dedicated functions back, two-wire float on, led float off
    led = 16'hc3a5;
    wr(SPFS_ADDR_SEL_A, 16'h0000);
    wr(SPFS_ADDR_SEL_B, 16'h2400);
    settle();
    chk({2'h0, pad_o}, 16'h15a5);
    chk({2'h0, pad_oe}, 16'h3e5f);
    chk({2'h0, core_in}, 16'h15a5);
    chk(led_oe, 16'hffff);
    chk(led_o, 16'hc3a5);
    wr(SPFS_ADDR_SEL_B, 16'h2600);
    settle();
    chk(led_oe, 16'h3c5a);
    wr(SPFS_ADDR_SEL_B, 16'h1100);
    settle();
    chk({14'h0000, hold_oe, hold_o}, 16'h0003);
    chk({10'h000, pps_oe, pps_o}, 16'h003d);
    rd(SPFS_ADDR_SEL_B, 16'h1900);
    // bit 11 written high must not stick; the pin reads low here
    wr(SPFS_ADDR_SEL_B, 16'h2800);
    settle();
    chk({15'h0000, hold_oe}, 16'h0000);
    rd(SPFS_ADDR_SEL_B, 16'h2000);
    wr(SPFS_ADDR_PAGE, SPFS_PAGE_MAIN);
    wr(SPFS_ADDR_SEL_A, 16'hffff);
    rd(SPFS_ADDR_SEL_A, 16'h0000);
    wr(SPFS_ADDR_PAGE, SPFS_PAGE_GP);
    rd(SPFS_ADDR_SEL_A, 16'h0000);
    // a frozen clock enable drops the write
    ce_i = 1'b0;
    wr(SPFS_ADDR_SEL_A, 16'hffff);
    ce_i = 1'b1;
    rd(SPFS_ADDR_SEL_A, 16'h0000);
    tally_and_finish();
  end
endmodule : spfs_top_tb_top
